// ===== pkg/stc_pkg.sv
// Package for the sixteen-bit timer/counter: widths, reset values and encodings.
// Assumes a single system clock at 20 MHz and a synchronous active-high reset.
package stc_pkg;
   localparam int STC_WIDTH = 16;
   localparam logic [15:0] STC_COUNT_RESET = 16'h0000;
   localparam logic [15:0] STC_MAX_COUNT = 16'hffff;
   localparam logic [15:0] STC_CAPTURE_RESET = 16'h0000;
   localparam logic [15:0] STC_COMPARE_RESET = 16'h0000;
   // Prescale select: divide by 2^(sel+3), so 0 gives 8 and 8 gives 2048.
   localparam int STC_PRESCALE_BASE = 3;
   localparam logic [3:0] STC_PRESCALE_MAX_SEL = 4'h8;
   localparam logic [3:0] STC_PRESCALE_RESET = 4'h0;
   localparam int STC_PRESCALE_CNT_W = 11;
   // Output mode encodings per timer output.
   typedef enum logic [1:0] {
      STC_OUT_FIXED,
      STC_OUT_TOGGLE,
      STC_OUT_PWM,
      STC_OUT_ONESHOT
   } stc_out_mode_type;
   // Event edge selection.
   typedef enum logic [1:0] {
      STC_EDGE_RISE,
      STC_EDGE_FALL,
      STC_EDGE_BOTH,
      STC_EDGE_NONE
   } stc_edge_type;
   localparam int STC_SYNC_STAGES = 2;
endpackage : stc_pkg

// ===== src/stc_edge_detect.sv
// Event input synchroniser and edge detector for the timer/counter.
// Assumes the event input is asynchronous to sys_clk_in.
`timescale 1ns/1ps
`default_nettype none
module stc_edge_detect
   import stc_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic clk_en_in,
   input wire logic event_in,
   input wire logic [1:0] edge_sel_in,
   output logic edge_out
);
   logic sync_a;
   logic sync_b;
   logic last;
   logic next_sync_a;
   logic next_sync_b;
   logic next_last;

   // Next values of the two synchroniser stages and the delayed sample.
   always_comb begin
      next_sync_a = event_in;
      next_sync_b = sync_a;
      next_last = sync_b;
   end

   // Registers of the synchroniser; only the second stage feeds the edge logic.
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         last <= 1'b0;
      end else if (clk_en_in) begin
         sync_a <= next_sync_a;
         sync_b <= next_sync_b;
         last <= next_last;
      end
   end

   // Picks the rising, falling or both edges as the valid edge.
   always_comb begin
      case (stc_edge_type'(edge_sel_in))
         STC_EDGE_RISE: edge_out = clk_en_in & sync_b & ~last;
         STC_EDGE_FALL: edge_out = clk_en_in & ~sync_b & last;
         STC_EDGE_BOTH: edge_out = clk_en_in & (sync_b ^ last);
         default: edge_out = 1'b0;
      endcase
   end
endmodule : stc_edge_detect
`default_nettype wire

// ===== src/stc_timer.sv
// Sixteen-bit timer/counter with two compare channels, capture and two timer outputs.
// Assumes software drives the control ports synchronously to sys_clk_in;
// the event input is a pin and is synchronised inside.
`timescale 1ns/1ps
`default_nettype none
module stc_timer
   import stc_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic clk_en_in,
   input wire logic count_enable_bit_in,
   input wire logic event_count_mode_in,
   input wire logic [3:0] prescale_sel_in,
   input wire logic [1:0] edge_sel_in,
   input wire logic clear_on_match_b_in,
   input wire logic [15:0] compare_a_data_in,
   input wire logic compare_a_write_in,
   input wire logic [15:0] compare_b_data_in,
   input wire logic compare_b_write_in,
   input wire logic overflow_clear_in,
   input wire logic [1:0] out_mode_a_in,
   input wire logic [1:0] out_mode_b_in,
   input wire logic out_enable_a_in,
   input wire logic out_enable_b_in,
   input wire logic active_low_a_in,
   input wire logic active_low_b_in,
   input wire logic oneshot_start_a_in,
   input wire logic oneshot_start_b_in,
   input wire logic ext_event_input,
   output logic [15:0] count_register_out,
   output logic [15:0] compare_reg_a_out,
   output logic [15:0] compare_reg_b_out,
   output logic [15:0] capture_reg_out,
   output logic overflow_flag_out,
   output logic compare_irq_a_out,
   output logic compare_irq_b_out,
   output logic capture_event_out,
   output logic timer_out_a_out,
   output logic timer_out_b_out
);
   // Elaboration check: the prescaler counter must hold the largest divide ratio minus one.
   // A narrower counter would wrap before it reached the limit and never tick.
   if ((1 << (int'(STC_PRESCALE_MAX_SEL) + STC_PRESCALE_BASE)) >
       (1 << STC_PRESCALE_CNT_W)) begin : g_prescale_check
      $error("Prescaler counter too narrow for the largest divide ratio.");
   end
   // Elaboration check: the register ports are fixed at sixteen bits.
   if (STC_WIDTH != 16) begin : g_width_check
      $error("Counter width must match the sixteen-bit register ports.");
   end

   // Divide ratio minus one for a prescale select, clamped to the largest ratio.
   function automatic logic [10:0] stc_div_limit(input logic [3:0] sel);
      logic [3:0] s;
      s = (sel > STC_PRESCALE_MAX_SEL) ? STC_PRESCALE_MAX_SEL : sel;
      stc_div_limit = 11'((32'd1 << (int'(s) + STC_PRESCALE_BASE)) - 32'd1);
   endfunction : stc_div_limit

   // A compare hit counts only on a count clock of a started, enabled counter.
   function automatic logic stc_hit(input logic run, input logic step,
                                    input logic [15:0] cnt, input logic [15:0] cmp_val);
      stc_hit = run & step & (cnt == cmp_val);
   endfunction : stc_hit

   // Next level of a timer output for its mode on match, overflow and software start.
   // Fixed mode and any unknown code hold the output at its inactive level.
   function automatic logic stc_out_next(input logic cur, input logic [1:0] mode,
                                         input logic match_own, input logic match_per,
                                         input logic ovf, input logic start);
      logic nxt;
      nxt = cur;
      case (stc_out_mode_type'(mode))
         STC_OUT_TOGGLE: nxt = match_own ? ~cur : cur;
         STC_OUT_PWM: begin
            if (match_own)
               nxt = 1'b0;
            else if (match_per | ovf)
               nxt = 1'b1;
         end
         STC_OUT_ONESHOT: begin
            if (start)
               nxt = 1'b1;
            else if (match_own)
               nxt = 1'b0;
         end
         default: nxt = 1'b0;
      endcase
      stc_out_next = nxt;
   endfunction : stc_out_next

   // Registered state of the counter, compare, capture and output paths.
   logic [10:0] prescale_cnt;
   logic [15:0] count;
   logic [15:0] cmp_a;
   logic [15:0] cmp_b;
   logic [15:0] cap;
   logic ovf_flag;
   logic started;
   logic out_a;
   logic out_b;
   logic irq_a;
   logic irq_b;
   logic cap_pulse;

   // Next values computed each cycle and registered below.
   logic [10:0] next_prescale_cnt;
   logic [15:0] next_count;
   logic [15:0] next_cmp_a;
   logic [15:0] next_cmp_b;
   logic [15:0] next_cap;
   logic next_ovf_flag;
   logic next_started;
   logic next_out_a;
   logic next_out_b;
   logic next_irq_a;
   logic next_irq_b;
   logic next_cap_pulse;

   // Strobes decoded in the current cycle.
   logic event_edge;
   logic tick;
   logic match_a;
   logic match_b;
   logic wrap;

   // Synchronised valid edge of the event input.
   // The pin is asynchronous, so only the detector's second stage reaches logic here.
   stc_edge_detect u_edge (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .clk_en_in(clk_en_in),
      .event_in(ext_event_input),
      .edge_sel_in(edge_sel_in),
      .edge_out(event_edge)
   );

   // Count clock selection: divided system clock or the event input edge.
   // The prescaler is held at zero while stopped, so the first count clock comes a full
   // divided period after enabling, as does every later one.
   always_comb begin
      next_prescale_cnt = prescale_cnt;
      tick = 1'b0;
      if (!count_enable_bit_in) begin
         next_prescale_cnt = '0;
      end else if (event_count_mode_in) begin
         tick = event_edge;
      end else if (prescale_cnt >= stc_div_limit(prescale_sel_in)) begin
         next_prescale_cnt = '0;
         tick = 1'b1;
      end else begin
         next_prescale_cnt = prescale_cnt + 11'h001;
      end
   end

   // Match signals only exist while counting and on a count clock edge.
   // The count is compared before it advances, so a request follows the count clock
   // that finds the compare value, and the counter then shows that value plus one, or zero where a clearing match b resets it.
   always_comb begin
      match_a = stc_hit(count_enable_bit_in & started, tick, count, cmp_a);
      match_b = stc_hit(count_enable_bit_in & started, tick, count, cmp_b);
      wrap = stc_hit(count_enable_bit_in & started, tick, count, STC_MAX_COUNT);
   end

   // Counter, overflow and start tracking.
   // The software clear is applied first, so an overflow in the same cycle wins.
   always_comb begin
      next_count = count;
      next_started = started;
      next_ovf_flag = ovf_flag;
      if (overflow_clear_in)
         next_ovf_flag = 1'b0;
      if (!count_enable_bit_in) begin
         next_count = STC_COUNT_RESET;
         next_started = 1'b0;
      end else if (tick) begin
         if (!started) begin
            next_count = STC_COUNT_RESET;
            next_started = 1'b1;
         end else if (match_b && clear_on_match_b_in) begin
            next_count = STC_COUNT_RESET;
         end else if (wrap) begin
            next_count = STC_COUNT_RESET;
            next_ovf_flag = 1'b1;
         end else begin
            next_count = count + 16'h0001;
         end
      end
   end

   // Compare writes, capture on valid edges and output generation.
   // Capture takes the count before this cycle's increment, so widths are whole count clocks.
   // Output b has no later match to start its PWM period, so it rises on overflow only.
   always_comb begin
      next_cmp_a = compare_a_write_in ? compare_a_data_in : cmp_a;
      next_cmp_b = compare_b_write_in ? compare_b_data_in : cmp_b;
      next_cap = cap;
      next_cap_pulse = 1'b0;
      if (count_enable_bit_in && started && event_edge) begin
         next_cap = count;
         next_cap_pulse = 1'b1;
      end
      next_irq_a = match_a;
      next_irq_b = match_b;
      next_out_a = stc_out_next(out_a, out_mode_a_in, match_a, match_b, wrap,
                                oneshot_start_a_in);
      next_out_b = stc_out_next(out_b, out_mode_b_in, match_b, match_b, wrap,
                                oneshot_start_b_in);
   end

   // State registers; clock enable low freezes everything.
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         prescale_cnt <= '0;
         count <= STC_COUNT_RESET;
         cmp_a <= STC_COMPARE_RESET;
         cmp_b <= STC_COMPARE_RESET;
         cap <= STC_CAPTURE_RESET;
         ovf_flag <= 1'b0;
         started <= 1'b0;
         out_a <= 1'b0;
         out_b <= 1'b0;
         irq_a <= 1'b0;
         irq_b <= 1'b0;
         cap_pulse <= 1'b0;
      end else if (clk_en_in) begin
         prescale_cnt <= next_prescale_cnt;
         count <= next_count;
         cmp_a <= next_cmp_a;
         cmp_b <= next_cmp_b;
         cap <= next_cap;
         ovf_flag <= next_ovf_flag;
         started <= next_started;
         out_a <= next_out_a;
         out_b <= next_out_b;
         irq_a <= next_irq_a;
         irq_b <= next_irq_b;
         cap_pulse <= next_cap_pulse;
      end
   end

   // Register views and pins; a disabled output shows its inactive level.
   // Pulse outputs are gated by the clock enable so that a frozen block repeats no request.
   always_comb begin
      count_register_out = count;
      compare_reg_a_out = cmp_a;
      compare_reg_b_out = cmp_b;
      capture_reg_out = cap;
      overflow_flag_out = ovf_flag;
      compare_irq_a_out = irq_a & clk_en_in;
      compare_irq_b_out = irq_b & clk_en_in;
      capture_event_out = cap_pulse & clk_en_in;
      timer_out_a_out = (out_enable_a_in & out_a) ^ active_low_a_in;
      timer_out_b_out = (out_enable_b_in & out_b) ^ active_low_b_in;
   end
endmodule : stc_timer
`default_nettype wire

// ===== tb/stc_event_source.sv
// Model of the pin source that feeds the timer's event input.
// Assumes the bench calls pulse just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module stc_event_source (
   input wire logic sys_clk_in,
   output logic ev_out
);
   // One high pulse then a low gap, each held four clocks or more.
   task automatic pulse(input int hi, input int lo);
      ev_out = 1'b1;
      repeat (hi < 4 ? 4 : hi) @(posedge sys_clk_in);
      #1 ev_out = 1'b0;
      repeat (lo < 4 ? 4 : lo) @(posedge sys_clk_in);
      #1;
   endtask : pulse
   // The pin rests low between pulses.
   initial ev_out = 1'b0;
endmodule : stc_event_source
`default_nettype wire

// ===== tb/stc_timer_sva.sv
// Port checker of the timer, bound to every stc_timer.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module stc_timer_sva (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic clk_en_in,
   input wire logic count_enable_bit_in,
   input wire logic clear_on_match_b_in,
   input wire logic overflow_clear_in,
   input wire logic [15:0] count_register_out,
   input wire logic [15:0] compare_reg_a_out,
   input wire logic [15:0] capture_reg_out,
   input wire logic overflow_flag_out,
   input wire logic compare_irq_a_out,
   input wire logic compare_irq_b_out,
   input wire logic capture_event_out
);
   // All checks use the system clock and rest during reset.
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (reset_in);
   // Counter, match, capture and overflow relations.
   AST_COUNT_STEP: assert property ($changed(count_register_out) |->
      count_register_out == $past(count_register_out) + 16'h0001 || count_register_out == 16'h0000)
      else $error("counter jumped");
   AST_STOP_CLEAR: assert property (clk_en_in && !count_enable_bit_in |=>
      count_register_out == 16'h0000) else $error("counter not cleared when stopped");
   AST_MATCH_A: assert property (compare_irq_a_out && !clear_on_match_b_in |->
      count_register_out == compare_reg_a_out + 16'h0001) else $error("irq a off match");
   AST_MATCH_B_CLEAR: assert property (compare_irq_b_out && clear_on_match_b_in |->
      count_register_out == 16'h0000) else $error("match b did not clear");
   AST_IRQ_PULSE: assert property (compare_irq_a_out || compare_irq_b_out |=>
      !compare_irq_a_out && !compare_irq_b_out) else $error("irq longer than a cycle");
   AST_OVF_STICKY: assert property (overflow_flag_out && !overflow_clear_in |=>
      overflow_flag_out) else $error("overflow flag lost");
   AST_OVF_SET: assert property (count_register_out == 16'h0000 &&
      $past(count_register_out) == 16'hffff && $past(count_enable_bit_in) &&
      !$past(clear_on_match_b_in) |-> overflow_flag_out) else $error("wrap without flag");
   AST_CAPTURE: assert property ($changed(capture_reg_out) |-> ##[0:1] capture_event_out)
      else $error("capture without event");
   AST_FREEZE: assert property (!clk_en_in |=> $stable(count_register_out) &&
      $stable(capture_reg_out) && $stable(overflow_flag_out))
      else $error("state moved while frozen");
endmodule : stc_timer_sva
bind stc_timer stc_timer_sva stc_timer_sva_inst (
   .sys_clk_in(sys_clk_in),
   .reset_in(reset_in),
   .clk_en_in(clk_en_in),
   .count_enable_bit_in(count_enable_bit_in),
   .clear_on_match_b_in(clear_on_match_b_in),
   .overflow_clear_in(overflow_clear_in),
   .count_register_out(count_register_out),
   .compare_reg_a_out(compare_reg_a_out),
   .capture_reg_out(capture_reg_out),
   .overflow_flag_out(overflow_flag_out),
   .compare_irq_a_out(compare_irq_a_out),
   .compare_irq_b_out(compare_irq_b_out),
   .capture_event_out(capture_event_out)
);
`default_nettype wire

// ===== tb/stc_timer_tb.sv
// Self-checking bench of the timer with the event source model.
// Assumes the checker is bound to the design.
`timescale 1ns/1ps
`default_nettype none
module stc_timer_tb
   import stc_pkg::*;
;
   logic sys_clk_in = 1'b0, reset_in = 1'b1, clk_en_in = 1'b1, count_enable_bit_in = 1'b0;
   logic event_count_mode_in = 1'b0, clear_on_match_b_in = 1'b0, overflow_clear_in = 1'b0;
   logic [3:0] prescale_sel_in = 4'h0;
   logic [1:0] edge_sel_in = 2'h0, out_mode_a_in = 2'h0, out_mode_b_in = 2'h0;
   logic [15:0] compare_a_data_in = 16'h0002, compare_b_data_in = 16'h0005, c1, ex;
   logic compare_a_write_in = 1'b0, compare_b_write_in = 1'b0, out_enable_a_in = 1'b1;
   logic out_enable_b_in = 1'b1, active_low_a_in = 1'b0, active_low_b_in = 1'b0, v;
   logic oneshot_start_a_in = 1'b0, oneshot_start_b_in = 1'b0, ext_event_input;
   logic [15:0] count_register_out, compare_reg_a_out, compare_reg_b_out, capture_reg_out;
   logic overflow_flag_out, compare_irq_a_out, compare_irq_b_out, capture_event_out;
   logic timer_out_a_out, timer_out_b_out;
   int mismatches = 0, checked = 0, n;
   stc_timer stc_timer_inst (.*);
   stc_event_source stc_event_source_inst (.sys_clk_in(sys_clk_in), .ev_out(ext_event_input));
   // The 20 MHz clock.
   always #25 sys_clk_in = ~sys_clk_in;
   // Steps k edges and lands just after the last.
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk_in);
      #1;
   endtask : tick
   // Compares one result and reports a mismatch.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Bounded wait for irq a (0), irq b (1) or a capture (2).
   task automatic wait_ev(input int w);
      n = 0;
      while ((w == 0 ? compare_irq_a_out : w == 1 ? compare_irq_b_out : capture_event_out)
             !== 1'b1 && n < 20000) begin
         tick(1);
         n++;
      end
      chk(16'(n < 20000), 16'h0001);
   endtask : wait_ev
   // Prints the verdict and ends the run.
   task automatic stop_test;
      if (mismatches == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test
   // Reset values, then both compare registers loaded together.
   task automatic t_reset;
      chk(count_register_out | capture_reg_out | compare_reg_a_out, 16'h0000);
      chk({overflow_flag_out, timer_out_a_out}, 2'b00);
      overflow_clear_in = 1'b1;
      compare_a_write_in = 1'b1;
      compare_b_write_in = 1'b1;
      tick(1);
      {overflow_clear_in, compare_a_write_in, compare_b_write_in} = 3'h0;
      chk(compare_reg_b_out - compare_reg_a_out, 16'h0003);
   endtask : t_reset
   // With clear on match b, irq b repeats every six count clocks at each divide.
   task automatic t_period;
      clear_on_match_b_in = 1'b1;
      count_enable_bit_in = 1'b1;
      for (int s = 0; s <= 8; s++) begin
         prescale_sel_in = 4'(s);
         tick(1);
         wait_ev(1);
         tick(1);
         wait_ev(1);
         chk(16'(n + 1), 16'(6 << (s + 3)));
      end
      prescale_sel_in = 4'h0;
   endtask : t_period
   // Match a inverts output a; the polarity bit inverts the pin; a disabled pin is inactive.
   task automatic t_toggle;
      out_mode_a_in = STC_OUT_TOGGLE;
      tick(2);
      repeat (3) begin
         v = timer_out_a_out;
         wait_ev(0);
         tick(2);
         chk(timer_out_a_out, !v);
      end
      active_low_a_in = 1'b1;
      tick(1);
      chk(timer_out_a_out, v);
      out_enable_a_in = 1'b0;
      tick(1);
      chk(timer_out_a_out, 1'b1);
      {active_low_a_in, out_enable_a_in} = 2'b01;
   endtask : t_toggle
   // PWM on output a: active from the match b period end, inactive from its own match.
   task automatic t_pwm;
      out_mode_a_in = STC_OUT_PWM;
      wait_ev(1);
      tick(2);
      chk(timer_out_a_out, 1'b1);
      wait_ev(0);
      tick(2);
      chk(timer_out_a_out, 1'b0);
   endtask : t_pwm
   // A start pulse drives both outputs active; each own match ends its pulse.
   task automatic t_oneshot;
      {out_mode_a_in, out_mode_b_in} = {STC_OUT_ONESHOT, STC_OUT_ONESHOT};
      wait_ev(0);
      tick(2);
      chk(timer_out_a_out, 1'b0);
      {oneshot_start_a_in, oneshot_start_b_in} = 2'b11;
      tick(1);
      {oneshot_start_a_in, oneshot_start_b_in} = 2'b00;
      chk({timer_out_a_out, timer_out_b_out}, 2'b11);
      wait_ev(1);
      tick(2);
      chk({timer_out_a_out, timer_out_b_out}, 2'b10);
      wait_ev(0);
      tick(2);
      chk(timer_out_a_out, 1'b0);
   endtask : t_oneshot
   // A high pulse of eighty clocks spans ten count clocks between captures.
   task automatic t_capture;
      clear_on_match_b_in = 1'b0;
      edge_sel_in = STC_EDGE_BOTH;
      fork
         stc_event_source_inst.pulse(80, 40);
         begin
            wait_ev(2);
            c1 = capture_reg_out;
            tick(1);
            wait_ev(2);
            chk(capture_reg_out - c1, 16'h000a);
         end
      join
   endtask : t_capture
   // In event mode the first edge only clears, then each valid edge adds one.
   task automatic t_event;
      count_enable_bit_in = 1'b0;
      event_count_mode_in = 1'b1;
      edge_sel_in = STC_EDGE_RISE;
      tick(1);
      count_enable_bit_in = 1'b1;
      repeat (5) stc_event_source_inst.pulse(4, 4);
      tick(4);
      ex = 16'h0004;
      chk(count_register_out, ex);
      for (int e = 0; e < 4; e++) begin
         edge_sel_in = 2'(e);
         repeat (3) stc_event_source_inst.pulse(4, 4);
         tick(4);
         ex = ex + 16'(3 * (e == 2 ? 2 : e < 2));
         chk(count_register_out, ex);
      end
   endtask : t_event
   // A low clock enable freezes the block; pin pulses in that time are not seen.
   task automatic t_freeze;
      edge_sel_in = STC_EDGE_RISE;
      clk_en_in = 1'b0;
      repeat (2) stc_event_source_inst.pulse(4, 4);
      chk(count_register_out, ex);
      clk_en_in = 1'b1;
      stc_event_source_inst.pulse(4, 4);
      tick(4);
      chk(count_register_out, ex + 16'h0001);
   endtask : t_freeze
   // Reset for twenty clocks, then every scenario.
   initial begin
      repeat (20) @(posedge sys_clk_in);
      #1 reset_in = 1'b0;
      tick(1);
      t_reset;
      t_period;
      t_toggle;
      t_pwm;
      t_oneshot;
      t_capture;
      t_event;
      t_freeze;
      stop_test;
   end
   // Watchdog at eighty thousand clocks.
   initial begin
      #4000000;
      mismatches++;
      stop_test;
   end
endmodule : stc_timer_tb
`default_nettype wire
